// [hw/sar_pkg.sv]
// shared constants for the converter readout sequencer and its serial master
// assumes both ends run on one 100 MHz clock and meet in sar_link_if
package sar_pkg;
   localparam int RES_W = 16;
   localparam int CNT_W = 6;
   localparam int CLK_HZ = 100_000_000;
   // counts of falling bit clock edges after select falls
   localparam logic [5:0] NULL_FALL = 6'h05;
   localparam logic [5:0] MSB_FALL = 6'h06;
   localparam logic [5:0] LSB_FALL = 6'h15;
   localparam logic [5:0] REV_END_FALL = 6'h24;
   localparam logic [5:0] TRI_FALL = 6'h25;
   // host timing: preferred bit clock rate, least select-high time
   localparam int BIT_CLK_HZ = 2_400_000;
   localparam int HALF_CYC = CLK_HZ / (2 * BIT_CLK_HZ);
   localparam int CS_HIGH_NS = 200;
   localparam int CS_HIGH_CYC = (CS_HIGH_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
   // host samples the msb at this rising edge count
   localparam logic [5:0] MSB_RISE = 6'h07;
   localparam int FIFO_DEPTH = 4;
   typedef enum logic [1:0] {SAR_IDLE, SAR_RUN, SAR_GAP} sar_hstate_t;
endpackage

// [hw/sar_link_if.sv]
// three-wire serial link between the serial master and the converter
// assumes the testbench resolves the shared data wire from dout_oe_n
`timescale 1ns/1ps
`default_nettype none
interface sar_link_if;
   logic cs_n;
   logic sclk;
   logic dout;
   logic dout_oe_n;
   modport dev (input cs_n, input sclk, output dout, output dout_oe_n);
   modport host (output cs_n, output sclk, input dout, input dout_oe_n);
endinterface
`default_nettype wire

// [hw/sar_fifo.sv]
// small first-in first-out buffer with valid/ready on both sides
// assumes one clock; width and depth shape the storage
`timescale 1ns/1ps
`default_nettype none
module sar_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 4
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_q;
   logic [AW-1:0] rd_q;
   logic [AW:0] cnt_q;
   logic push;
   logic pop;

   assign in_ready = (cnt_q != (AW+1)'(DEPTH));
   assign out_valid = (cnt_q != '0);
   assign out_data = mem[rd_q];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   // storage has no reset; only written slots are ever read
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_q] <= in_data;
      end
   end

   // pointers wrap at the depth, which is a power of two
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end else begin
         if (push) begin
            wr_q <= wr_q + AW'(1);
         end
         if (pop) begin
            rd_q <= rd_q + AW'(1);
         end
         cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule
`default_nettype wire

// [hw/sar_dev.sv]
// converter end: acquisition, bit-per-clock decisions and serial readout
// assumes select and bit clock arrive as pins from the master and are
// resampled on clk; sample_in is the digitised analog level
//
// Functional notes
// RQ1: data changes on each bit clock fall
// RQ2: master samples data on rising clock edge
// RQ3: select falling starts conversion and transfer
// RQ4: first 4.5 to 5 periods acquire input
// RQ5: fifth fall enables output, drives null low
// RQ6: sixteen result bits follow, msb first
// RQ7: after lsb, clocks resend result lsb first
// RQ8: after resent msb output floats, clocks ignored
// RQ9: new conversion only after select high-low
// RQ10: result is unsigned straight binary
// RQ11: power down on completion or select high
// RQ12: select low keeps digital on, analog off
// RQ13: master clocks fast, then holds select high
// RQ14: bits leave as decided; select aborts anytime
// RQ15: one decision per clock, output same cycle
// RQ16: full cycles supported up to 100kHz
// RQ17: shifted bits belong to current conversion
// RQ18: output floats while select high and acquiring
`timescale 1ns/1ps
`default_nettype none
module sar_dev (
   input wire logic clk,
   input wire logic rst,
   sar_link_if.dev link,
   input wire logic [15:0] sample_in,
   output logic analog_pd,
   output logic digital_pd,
   output logic [15:0] result,
   output logic result_valid
);
   logic cs_s1_q;
   logic cs_s2_q;
   logic cs_s3_q;
   logic ck_s1_q;
   logic ck_s2_q;
   logic ck_s3_q;
   logic [5:0] cnt_q;
   logic [5:0] cnt_nx;
   logic [15:0] hold_q;
   logic [15:0] smp_s1_q;
   logic [15:0] smp_s2_q;
   logic [15:0] res_q;
   logic [3:0] idx;
   logic dec_bit;
   logic fall;
   logic cs_fall;
   logic dout_q;
   logic oe_n_q;
   logic analog_pd_q;
   logic digital_pd_q;
   logic [15:0] result_q;
   logic result_valid_q;

   // one comparator decision: keep the trial bit when the input reaches it
   function automatic logic sar_decide(input logic [15:0] res, input logic [3:0] i,
                                       input logic [15:0] lvl);
      logic [15:0] trial;
      trial = res | (16'h0001 << i);
      return lvl >= trial;
   endfunction

   // pins come from the master's domain, so two flops before any use
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cs_s1_q <= 1'b1;
         cs_s2_q <= 1'b1;
         cs_s3_q <= 1'b1;
         ck_s1_q <= 1'b0;
         ck_s2_q <= 1'b0;
         ck_s3_q <= 1'b0;
      end else begin
         cs_s1_q <= link.cs_n;
         cs_s2_q <= cs_s1_q;
         cs_s3_q <= cs_s2_q;
         ck_s1_q <= link.sclk;
         ck_s2_q <= ck_s1_q;
         ck_s3_q <= ck_s2_q;
      end
   end

   // the level comes from outside the clock domain as well; it must hold
   // still around the select fall, because a word resampled while it moves
   // may tear between bits
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         smp_s1_q <= '0;
         smp_s2_q <= '0;
      end else begin
         smp_s1_q <= sample_in;
         smp_s2_q <= smp_s1_q;
      end
   end

   // maps a fall count onto the result bit decided at that fall
   function automatic logic [3:0] sarlo(input logic [5:0] n);
      logic [5:0] k;
      k = 6'h0f - (n - sar_pkg::MSB_FALL);
      return k[3:0];
   endfunction

   // edge detectors look only at the second and third stages
   assign fall = ck_s3_q && !ck_s2_q && !cs_s2_q; // RQ1
   assign cs_fall = cs_s3_q && !cs_s2_q; // RQ3
   // a cycle that stops at the lsb needs 22 bit clocks, so the preferred
   // bit clock keeps a 100kHz frame rate in reach; the counter never wraps
   assign cnt_nx = cnt_q + 6'h01; // RQ16
   // bit index of the decision made at this fall: msb at the sixth
   assign idx = 4'(sarlo(cnt_nx));
   assign dec_bit = sar_decide(res_q, idx, hold_q); // RQ15

   // fall counter; it stops at the float point so extra clocks do nothing
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_q <= '0;
      end else if (cs_s2_q || cs_fall) begin
         cnt_q <= '0; // RQ9
      end else if (fall && cnt_q != sar_pkg::TRI_FALL) begin
         cnt_q <= cnt_nx; // RQ8
      end
   end

   // capture the level at the select fall; acquisition covers the first
   // five falls, so the stored copy stands for the held capacitor array
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         hold_q <= '0;
      end else if (cs_fall) begin
         hold_q <= smp_s2_q; // RQ4 RQ10
      end
   end

   // successive approximation register, cleared for each conversion so
   // no earlier result can leak into this transfer
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         res_q <= '0;
      end else if (cs_fall) begin
         res_q <= '0; // RQ17
      end else if (fall && cnt_nx >= sar_pkg::MSB_FALL && cnt_nx <= sar_pkg::LSB_FALL) begin
         res_q[idx] <= dec_bit; // RQ15
      end
   end

   // serial output: null, msb first, then lsb first, then float
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         dout_q <= 1'b0;
         oe_n_q <= 1'b1;
      end else if (cs_s2_q) begin
         dout_q <= 1'b0;
         oe_n_q <= 1'b1; // RQ18
      end else if (fall && cnt_q != sar_pkg::TRI_FALL) begin
         if (cnt_nx < sar_pkg::NULL_FALL) begin
            oe_n_q <= 1'b1; // RQ18
         end else if (cnt_nx == sar_pkg::NULL_FALL) begin
            dout_q <= 1'b0; // RQ5
            oe_n_q <= 1'b0;
         end else if (cnt_nx <= sar_pkg::LSB_FALL) begin
            dout_q <= dec_bit; // RQ6 RQ14
         end else if (cnt_nx <= sar_pkg::REV_END_FALL) begin
            dout_q <= res_q[4'(cnt_nx - sar_pkg::LSB_FALL)]; // RQ7
         end else begin
            dout_q <= 1'b0;
            oe_n_q <= 1'b1; // RQ8
         end
      end
   end

   // completed word and a one-cycle strobe once the lsb is decided
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         result_q <= '0;
         result_valid_q <= 1'b0;
      end else begin
         result_valid_q <= fall && cnt_nx == sar_pkg::LSB_FALL;
         if (fall && cnt_nx == sar_pkg::LSB_FALL) begin
            result_q <= {res_q[15:1], dec_bit}; // RQ10
         end
      end
   end

   // analog section sleeps once the lsb is decided or select is high;
   // digital section sleeps only with select high, since a low select
   // with a running clock must still shift the reversed word out
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         analog_pd_q <= 1'b1;
         digital_pd_q <= 1'b1;
      end else begin
         analog_pd_q <= cs_s2_q || cnt_q >= sar_pkg::LSB_FALL; // RQ11
         digital_pd_q <= cs_s2_q; // RQ12
      end
   end

   assign link.dout = dout_q;
   assign link.dout_oe_n = oe_n_q;
   assign analog_pd = analog_pd_q;
   assign digital_pd = digital_pd_q;
   assign result = result_q;
   assign result_valid = result_valid_q;
endmodule
`default_nettype wire

// [hw/sar_host.sv]
// serial master end: makes the bit clock, frames select, collects bits
// assumes the converter shares this clock; dout still passes two flops
`timescale 1ns/1ps
`default_nettype none
module sar_host (
   input wire logic clk,
   input wire logic rst,
   sar_link_if.host link,
   input wire logic req,
   input wire logic [4:0] nbits,
   output logic req_ready,
   output logic word_valid,
   input wire logic word_ready,
   output logic [15:0] word
);
   sar_pkg::sar_hstate_t state_q;
   logic cs_n_q;
   logic sclk_q;
   logic [7:0] div_q;
   logic [5:0] rise_q;
   logic [5:0] last_q;
   logic [15:0] shreg_q;
   logic [7:0] gap_q;
   logic push_q;
   logic rdy_q;
   logic d_s1_q;
   logic d_s2_q;
   logic fifo_in_ready;
   logic take;
   logic tick;

   assign take = req && rdy_q;
   assign tick = (div_q == 8'(sar_pkg::HALF_CYC - 1));

   // data pin is resampled before use
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         d_s1_q <= 1'b0;
         d_s2_q <= 1'b0;
      end else begin
         d_s1_q <= link.dout;
         d_s2_q <= d_s1_q;
      end
   end

   // frame sequencer; a new request waits until the buffer has room
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_q <= sar_pkg::SAR_IDLE;
         cs_n_q <= 1'b1;
         sclk_q <= 1'b0;
         div_q <= '0;
         rise_q <= '0;
         last_q <= '0;
         shreg_q <= '0;
         gap_q <= '0;
         push_q <= 1'b0;
      end else begin
         push_q <= 1'b0;
         unique case (state_q)
            sar_pkg::SAR_IDLE: begin
               if (take) begin
                  cs_n_q <= 1'b0; // RQ3
                  sclk_q <= 1'b0;
                  div_q <= '0;
                  rise_q <= '0;
                  shreg_q <= '0;
                  // short cycle: stop after the requested bits, 0 means 16
                  last_q <= sar_pkg::MSB_RISE - 6'h01 + ((nbits == 5'h00) ? 6'h10 :
                            6'(nbits > 5'h10 ? 5'h10 : nbits)); // RQ14
                  state_q <= sar_pkg::SAR_RUN;
               end
            end
            sar_pkg::SAR_RUN: begin
               div_q <= tick ? '0 : div_q + 8'h01;
               if (tick) begin
                  sclk_q <= !sclk_q;
                  if (!sclk_q) begin
                     rise_q <= rise_q + 6'h01;
                     // sample on the rising edge, msb lands in bit 15
                     if (rise_q + 6'h01 >= sar_pkg::MSB_RISE) begin
                        shreg_q[4'(6'h0f - (rise_q + 6'h01 - sar_pkg::MSB_RISE))] <= d_s2_q; // RQ2
                     end
                     if (rise_q + 6'h01 == last_q) begin
                        cs_n_q <= 1'b1; // RQ13
                        sclk_q <= 1'b0;
                        gap_q <= '0;
                        state_q <= sar_pkg::SAR_GAP;
                     end
                  end
               end
            end
            sar_pkg::SAR_GAP: begin
               // select stays high long enough for the converter to see it
               gap_q <= gap_q + 8'h01;
               if (gap_q == 8'(sar_pkg::CS_HIGH_CYC - 1)) begin
                  push_q <= 1'b1; // RQ9
                  state_q <= sar_pkg::SAR_IDLE;
               end
            end
            default: state_q <= sar_pkg::SAR_IDLE;
         endcase
      end
   end

   // ready is registered; it drops the cycle after a request is taken
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rdy_q <= 1'b0;
      end else begin
         rdy_q <= state_q == sar_pkg::SAR_IDLE && !take && !push_q && fifo_in_ready;
      end
   end

   sar_fifo #(.WIDTH(sar_pkg::RES_W), .DEPTH(sar_pkg::FIFO_DEPTH)) u_fifo (
      .clk(clk),
      .rst(rst),
      .in_valid(push_q),
      .in_ready(fifo_in_ready),
      .in_data(shreg_q),
      .out_valid(word_valid),
      .out_ready(word_ready),
      .out_data(word)
   );

   assign link.cs_n = cs_n_q;
   assign link.sclk = sclk_q;
   assign req_ready = rdy_q;
endmodule
`default_nettype wire

// [dv/sar_link_chk.sv]
// checker for the serial link joining master and converter
// assumes one clk; dout settles a few clks after each bit clock fall
`timescale 1ns/1ps
`default_nettype none
module sar_link_chk (
   input wire logic clk,
   input wire logic rst,
   input wire logic cs_n,
   input wire logic sclk,
   input wire logic dout,
   input wire logic dout_oe_n
);
   logic sclk_q;
   logic [5:0] fcnt_q;
   logic [3:0] since_q;
   logic fall;
   logic rise;
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   assign fall = sclk_q & ~sclk;
   assign rise = ~sclk_q & sclk;
   // falls since select went low, and clks since the last fall
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sclk_q <= 1'b0;
         fcnt_q <= 6'h00;
         since_q <= 4'hf;
      end else begin
         sclk_q <= sclk;
         fcnt_q <= cs_n ? 6'h00 : fcnt_q + {5'h00, fall & (fcnt_q != 6'h3f)};
         since_q <= fall ? 4'h0 : since_q + {3'h0, since_q != 4'hf};
      end
   end
   null_bit_a: assert property (
      fall && fcnt_q == 6'h04 |-> ##[2:5] (!dout_oe_n && !dout)) else $error("null bit missing");
   oe_window_a: assert property (
      rise && !cs_n && fcnt_q >= 6'h05 && fcnt_q <= 6'h15 |-> !dout_oe_n)
      else $error("output off in result window");
   acq_float_a: assert property (!cs_n && fcnt_q < 6'h05 |-> dout_oe_n)
      else $error("output driven while acquiring");
   abort_float_a: assert property ($rose(cs_n) |-> ##[1:6] dout_oe_n)
      else $error("output not released after select rose");
   data_on_fall_a: assert property (
      !dout_oe_n && !$past(dout_oe_n) && $changed(dout) |-> since_q < 4'h7)
      else $error("data changed away from a clock fall");
   idle_clock_a: assert property (cs_n |-> !sclk)
      else $error("bit clock high outside a frame");
   half_period_a: assert property ($changed(sclk) |=> $stable(sclk)[*8])
      else $error("bit clock half period too short");
   cs_gap_a: assert property ($rose(cs_n) |=> cs_n[*8])
      else $error("select high gap too short");
   null_c: cover property (fall && fcnt_q == 6'h04);
   full_frame_c: cover property (rise && fcnt_q == 6'h15);
   short_cycle_c: cover property ($rose(cs_n) && fcnt_q > 6'h05 && fcnt_q < 6'h15);
endmodule
`default_nettype wire

// [dv/tb_sar_adc_serial_readout.sv]
// bench: master and converter on one link, a bench-driven second link
// assumes one 100 MHz clock; inputs change on the falling edge
`timescale 1ns/1ps
`default_nettype none
module tb_sar_adc_serial_readout;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic req = 1'b0;
   logic [4:0] nbits = 5'h00;
   logic word_ready = 1'b0;
   logic [15:0] smp = 16'h0000;
   logic [15:0] smp2 = 16'h0000;
   logic req_ready, word_valid, analog_pd, digital_pd, result_valid, dq2;
   logic [15:0] word, result;
   logic [15:0] expq[$];
   logic [4:0] cn[6] = '{5'h00, 5'h10, 5'h01, 5'h0f, 5'h1f, 5'h03};
   logic [15:0] cv[6] = '{16'hffff, 16'h0000, 16'h8001, 16'ha5a5, 16'h1234, 16'hfffe};
   int n_mismatch = 0;
   int comparisons = 0;
   int seed = 66106;
   sar_link_if link ();
   sar_link_if link2 ();
   always #5 clk = ~clk;
   // second link's wire floats once the converter lets go
   assign dq2 = link2.dout_oe_n ? 1'bz : link2.dout;
   sar_dev sar_dev_inst (.clk(clk), .rst(rst), .link(link.dev), .sample_in(smp),
      .analog_pd(analog_pd), .digital_pd(digital_pd), .result(result),
      .result_valid(result_valid));
   sar_dev sar_dev_inst2 (.clk(clk), .rst(rst), .link(link2.dev), .sample_in(smp2),
      .analog_pd(), .digital_pd(), .result(), .result_valid());
   sar_host sar_host_inst (.clk(clk), .rst(rst), .link(link.host), .req(req), .nbits(nbits),
      .req_ready(req_ready), .word_valid(word_valid), .word_ready(word_ready), .word(word));
   sar_link_chk sar_link_chk_inst (.clk(clk), .rst(rst), .cs_n(link.cs_n),
      .sclk(link.sclk), .dout(link.dout), .dout_oe_n(link.dout_oe_n));
   task automatic report_and_stop();
      $display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk(input string what, input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   // bounded wait; running out counts as a mismatch
   task automatic wait_for(ref logic sig, input logic val);
      int t;
      t = 0;
      while (sig !== val && t < 4000) begin
         @(negedge clk);
         t++;
      end
      chk("wait", {15'h0, sig}, {15'h0, val});
   endtask
   function automatic logic [15:0] expw(input logic [4:0] n, input logic [15:0] s);
      return (n == 5'h00 || n >= 5'h10) ? s : s & ~(16'hffff >> n);
   endfunction
   // wire level seen at the rise after m falls
   function automatic logic ebit(input int m, input logic [15:0] s);
      if (m < 5 || m > 36)
         return 1'bz;
      if (m == 5)
         return 1'b0;
      return (m <= 21) ? s[21 - m] : s[m - 21];
   endfunction
   // one request; sample held until the converter has captured it
   task automatic frame(input logic [4:0] n, input logic [15:0] s, input bit pwr);
      @(negedge clk);
      smp = s;
      nbits = n;
      req = 1'b1;
      wait_for(req_ready, 1'b1);
      @(negedge clk);
      req = 1'b0;
      expq.push_back(expw(n, s));
      repeat (10) @(negedge clk);
      if (pwr) begin
         repeat (240) @(negedge clk);
         chk("pd", {14'h0, analog_pd, digital_pd}, 16'h0000);
         if (n == 5'h00 || n >= 5'h10) begin
            wait_for(result_valid, 1'b1);
            chk("result", result, s);
            repeat (2) @(negedge clk);
            chk("pd", {14'h0, analog_pd, digital_pd}, 16'h0002);
         end
      end
   endtask
   task automatic pop();
      wait_for(word_valid, 1'b1);
      chk("word", word, expq.pop_front());
      word_ready = 1'b1;
      @(negedge clk);
      word_ready = 1'b0;
      // let an edge pass so a following pop never re-raises ready at once
      @(negedge clk);
   endtask
   // bench clocks the second converter past the reversed readout
   task automatic raw(input logic [15:0] s);
      smp2 = s;
      link2.cs_n = 1'b0;
      repeat (20) @(negedge clk);
      for (int k = 1; k <= 41; k++) begin
         link2.sclk = 1'b1;
         chk("dq2", {15'h0, dq2}, {15'h0, ebit(k - 1, s)});
         repeat (20) @(negedge clk);
         link2.sclk = 1'b0;
         repeat (20) @(negedge clk);
      end
      link2.cs_n = 1'b1;
      repeat (20) @(negedge clk);
   endtask
   // main sequence: corners, random frames, fifo full, reversed readout
   initial begin
      link2.cs_n = 1'b1;
      link2.sclk = 1'b0;
      repeat (5) @(posedge clk);
      @(negedge clk);
      rst = 1'b0;
      for (int i = 0; i < 6; i++) begin
         frame(cn[i], cv[i], 1'b1);
         pop();
      end
      for (int i = 0; i < 8; i++) begin
         frame(5'($random(seed)), 16'($random(seed)), 1'b1);
         pop();
      end
      for (int i = 0; i < 4; i++) begin
         frame(5'($random(seed)), 16'($random(seed)), 1'b0);
      end
      req = 1'b1;
      repeat (3000) @(negedge clk);
      chk("full", {14'h0, req_ready, link.cs_n}, 16'h0001);
      req = 1'b0;
      repeat (4) pop();
      chk("empty", {15'h0, word_valid}, 16'h0000);
      raw(16'h8001);
      raw(16'($random(seed)));
      report_and_stop();
   end
   // hang guard: the sequence needs at most about 20k clocks
   initial begin
      repeat (60000) @(posedge clk);
      n_mismatch++;
      report_and_stop();
   end
endmodule
`default_nettype wire
